/* core/cdg_pkg.sv */
// Shared constants, register map and state codes for the processor to DRAM glue
// Contract
// RULE1: Address-latch and access-read strobes fall together to start each memory cycle.
// RULE2: Two-stage shifter makes strobes; stage one drives access-read, stage two gates latch.
// RULE3: Processor memory-cycle enable is routed to the controller refresh request.
// RULE4: Refresh request high at least 2 clocks; low no longer than 3 memory cycles.
// RULE5: Controller drops ready and adds a wait when refresh overlaps a new request.
// RULE6: Controller ready is delayed by a flop before it reaches the processor.
// RULE7: Both sequence lines low makes the correction unit generate check bits.
// RULE8: Write column strobe waits for valid data plus check-bit generation time.
// RULE9: Rising first sequence line captures array data and check bits on reads.
// RULE10: Falling second sequence line latches read data and starts the error check.
// RULE11: Single-bit error is corrected and raises the single-error flag.
// RULE12: Double-bit error raises the double-error flag and data stays uncorrected.
// RULE13: First sequence line falling drives checked data onto the processor bus.
// RULE14: Whole correction sequence fits inside the normal memory cycle, no waits.
// RULE15: After reset all shifter stages sit inactive high.
`default_nettype none
package cdg_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    // Register byte offsets
    localparam logic [7:0] CDG_CTRL_OFS = 8'h00;
    localparam logic [7:0] CDG_STAT_OFS = 8'h04;
    localparam logic [7:0] CDG_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] CDG_IRQ_MASK_OFS = 8'h0c;
    // Control fields
    localparam int CDG_CTRL_ECC_EN_BIT = 0;
    localparam logic [1:0] CDG_CTRL_RESET = 2'h1;
    localparam int CDG_CTRL_FORCE_REF_BIT = 1;
    // Event bits, shared by status and mask
    localparam int CDG_EV_SINGLE = 0;
    localparam int CDG_EV_DOUBLE = 1;
    localparam int CDG_EV_WAIT = 2;
    localparam int CDG_EV_STARVE = 3;
    localparam int CDG_EV_LATE = 4;
    localparam int CDG_EV_W = 5;
    localparam logic [4:0] CDG_MASK_RESET = 5'h00;
    // Timing, clock 40 MHz
    localparam int CDG_CLK_PERIOD_PS = 25000;
    localparam int CDG_REF_MIN_HIGH_CLKS = 2;
    localparam int CDG_REF_MAX_LOW_CYCLES = 3;
    localparam int CDG_CHECK_GEN_NS = 30;
    localparam int CDG_CAPTURE_NS = 25;
    localparam int CDG_DETECT_NS = 50;
    // Least times round up, none under one cycle
    localparam int CDG_CHECK_GEN_CLKS = ((CDG_CHECK_GEN_NS * 1000 + CDG_CLK_PERIOD_PS - 1)
        / CDG_CLK_PERIOD_PS) < 1 ? 1 : ((CDG_CHECK_GEN_NS * 1000 + CDG_CLK_PERIOD_PS - 1)
        / CDG_CLK_PERIOD_PS);
    localparam int CDG_CAPTURE_CLKS = ((CDG_CAPTURE_NS * 1000 + CDG_CLK_PERIOD_PS - 1)
        / CDG_CLK_PERIOD_PS) < 1 ? 1 : ((CDG_CAPTURE_NS * 1000 + CDG_CLK_PERIOD_PS - 1)
        / CDG_CLK_PERIOD_PS);
    localparam int CDG_DETECT_CLKS = ((CDG_DETECT_NS * 1000 + CDG_CLK_PERIOD_PS - 1)
        / CDG_CLK_PERIOD_PS) < 1 ? 1 : ((CDG_DETECT_NS * 1000 + CDG_CLK_PERIOD_PS - 1)
        / CDG_CLK_PERIOD_PS);
    // Correction sequencer states
    typedef enum logic [2:0] {
        CDG_IDLE = 3'b000,
        CDG_WR_GEN = 3'b001,
        CDG_WR_CAS = 3'b010,
        CDG_RD_CAPT = 3'b011,
        CDG_RD_CHECK = 3'b100,
        CDG_RD_DRIVE = 3'b101,
        CDG_BYPASS = 3'b110
    } cdg_state_t;
endpackage
`default_nettype wire

/* core/cdg_strobe_shift.sv */
// Two-stage strobe shifter that launches each memory cycle
`default_nettype none
module cdg_strobe_shift
    import cdg_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic memory_cycle_enable_n,
    output logic access_read_strobe_n,
    output logic address_latch_strobe,
    output logic cycle_start
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic stage1;
        logic stage2;
        logic ale;
    } cdg_shift_t;

    cdg_shift_t s_q;
    cdg_shift_t s_d;

    // Stage one follows the enable, stage two trails it by a clock
    always_comb
    begin
        s_d = s_q;
        s_d.stage1 = memory_cycle_enable_n; // RULE2
        s_d.stage2 = s_q.stage1; // RULE2
        // Gating with stage one makes the latch strobe fall with access-read
        s_d.ale = s_d.stage1 & s_d.stage2; // RULE1
    end

    // All stages idle high after reset so nothing starts early
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_q <= '{stage1: 1'b1, stage2: 1'b1, ale: 1'b1}; // RULE15
        else
            s_q <= s_d;
    end

    assign access_read_strobe_n = s_q.stage1; // RULE2
    assign address_latch_strobe = s_q.ale;
    assign cycle_start = s_q.stage1 & ~memory_cycle_enable_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    strobes_fall_together_a: assert property ($fell(access_read_strobe_n) |-> // RULE1
        $fell(address_latch_strobe))
        else $error("latch strobe did not fall with access-read");
    shift_two_stage_a: assert property (!memory_cycle_enable_n ##1 !memory_cycle_enable_n // RULE2
        |=> !access_read_strobe_n && !address_latch_strobe)
        else $error("strobes not low two clocks into a request");
    latch_rise_late_a: assert property ($rose(access_read_strobe_n) |-> // RULE2
        !address_latch_strobe)
        else $error("latch strobe rose with access-read");
    cycle_start_c: cover property ($fell(access_read_strobe_n));
endmodule
`default_nettype wire

/* core/cdg_glue.sv */
// Processor to DRAM controller glue with correction sequencing and APB registers
`default_nettype none
module cdg_glue
    import cdg_pkg::*;
#(
    parameter int MEM_CYCLE_CLKS = 4
)
(
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Processor side
    input wire logic memory_cycle_enable_n,
    input wire logic cpu_write,
    output logic cpu_ready,
    // DRAM controller side
    output logic access_read_strobe_n,
    output logic address_latch_strobe,
    output logic refresh_request,
    input wire logic ctrl_ready,
    output logic column_strobe_allow,
    // Correction unit side
    output logic ecc_sequence_a,
    output logic ecc_sequence_b,
    input wire logic single_error_flag,
    input wire logic double_error_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] GEN_CNT = 8'(CDG_CHECK_GEN_CLKS - 1);
    localparam logic [7:0] CAPT_CNT = 8'(CDG_CAPTURE_CLKS - 1);
    localparam logic [7:0] DET_CNT = 8'(CDG_DETECT_CLKS - 1);
    localparam logic [7:0] REF_MIN = 8'(CDG_REF_MIN_HIGH_CLKS);
    localparam logic [7:0] STARVE_MAX = 8'(CDG_REF_MAX_LOW_CYCLES * MEM_CYCLE_CLKS);
    localparam int LOW_MAX = CDG_REF_MAX_LOW_CYCLES * MEM_CYCLE_CLKS;
    localparam int SEQ_MAX = CDG_CAPTURE_CLKS + CDG_DETECT_CLKS;

    typedef struct packed {
        cdg_state_t state;
        logic [7:0] seq_cnt;
        logic [7:0] ref_cnt;
        logic ref_req;
        logic ready_dly;
        logic seq_a;
        logic seq_b;
        logic cas_allow;
        logic [1:0] ctrl;
        logic [CDG_EV_W-1:0] ev_stat;
        logic [CDG_EV_W-1:0] ev_mask;
        logic [31:0] rdata;
    } cdg_glue_t;

    cdg_glue_t r_q;
    cdg_glue_t r_d;
    logic cycle_start;
    logic wr_acc;
    logic rd_acc;
    logic [CDG_EV_W-1:0] ev_set;

    // Register decode, shared by read and write paths
    function automatic logic known_ofs(input logic [7:0] a);
        known_ofs = (a == CDG_CTRL_OFS) || (a == CDG_STAT_OFS) ||
            (a == CDG_IRQ_STAT_OFS) || (a == CDG_IRQ_MASK_OFS);
    endfunction

    cdg_strobe_shift u_shift (
        .clk(clk),
        .resetn(resetn),
        .memory_cycle_enable_n(memory_cycle_enable_n),
        .access_read_strobe_n(access_read_strobe_n),
        .address_latch_strobe(address_latch_strobe),
        .cycle_start(cycle_start)
    );

    // Zero-wait slave; access phase completes on its first edge
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~known_ofs(paddr);
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & ~penable & ~pwrite;

    // Next-state logic for everything the glue remembers
    always_comb
    begin
        r_d = r_q;
        ev_set = '0;
        // Delay ready by a flop: processor samples it mid first phase
        r_d.ready_dly = ctrl_ready; // RULE6
        // A dropped ready inside an access is the controller's inserted wait
        ev_set[CDG_EV_WAIT] = ~ctrl_ready & ~access_read_strobe_n; // RULE5

        // Refresh request follows the enable, held high for the minimum window
        if (r_q.ref_req)
        begin
            if (r_q.ref_cnt < REF_MIN)
                r_d.ref_cnt = r_q.ref_cnt + 8'h01;
            if (memory_cycle_enable_n == 1'b0 && r_q.ref_cnt >= REF_MIN - 8'h01
                && !r_q.ctrl[CDG_CTRL_FORCE_REF_BIT])
            begin
                r_d.ref_req = 1'b0; // RULE4
                r_d.ref_cnt = 8'h00;
            end
        end
        else
        begin
            r_d.ref_cnt = r_q.ref_cnt + 8'h01;
            if (memory_cycle_enable_n || r_q.ctrl[CDG_CTRL_FORCE_REF_BIT])
            begin
                r_d.ref_req = 1'b1; // RULE3
                r_d.ref_cnt = 8'h00;
            end
            else if (r_q.ref_cnt >= STARVE_MAX - 8'h01)
            begin
                // Starved: force a refresh window, better a wait than lost data
                r_d.ref_req = 1'b1; // RULE4
                r_d.ref_cnt = 8'h00;
                ev_set[CDG_EV_STARVE] = 1'b1;
            end
        end

        // Correction sequencer
        if (r_q.seq_cnt != 8'h00)
            r_d.seq_cnt = r_q.seq_cnt - 8'h01;
        case (r_q.state)
            CDG_IDLE:
            begin
                // Both lines low here: unit is generating check bits
                if (cycle_start)
                begin
                    if (!r_q.ctrl[CDG_CTRL_ECC_EN_BIT])
                        r_d.state = CDG_BYPASS;
                    else if (cpu_write)
                    begin
                        r_d.state = CDG_WR_GEN; // RULE7
                        r_d.seq_cnt = GEN_CNT;
                    end
                    else
                    begin
                        r_d.state = CDG_RD_CAPT; // RULE9
                        r_d.seq_cnt = CAPT_CNT;
                    end
                end
            end
            CDG_WR_GEN:
                if (r_q.seq_cnt == 8'h00)
                    r_d.state = CDG_WR_CAS; // RULE8
            CDG_RD_CAPT:
                if (r_q.seq_cnt == 8'h00)
                begin
                    r_d.state = CDG_RD_CHECK; // RULE10
                    r_d.seq_cnt = DET_CNT;
                end
            CDG_RD_CHECK:
                if (r_q.seq_cnt == 8'h00)
                    r_d.state = CDG_RD_DRIVE; // RULE13
            CDG_RD_DRIVE:
            begin
                // Flags from the unit are valid once data is driven
                ev_set[CDG_EV_SINGLE] = single_error_flag; // RULE11
                ev_set[CDG_EV_DOUBLE] = double_error_flag; // RULE12
            end
            CDG_WR_CAS, CDG_BYPASS: ;
            default: r_d.state = CDG_IDLE;
        endcase
        // Cycle end returns home; ending before the sequence finished is late
        if (memory_cycle_enable_n && r_q.state != CDG_IDLE)
        begin
            if (r_q.state != CDG_WR_CAS && r_q.state != CDG_RD_DRIVE
                && r_q.state != CDG_BYPASS)
                ev_set[CDG_EV_LATE] = 1'b1; // RULE14
            r_d.state = CDG_IDLE;
        end
        // Sequence lines and column gate come straight from the next state
        r_d.seq_a = (r_d.state == CDG_RD_CAPT) || (r_d.state == CDG_RD_CHECK); // RULE9
        r_d.seq_b = (r_d.state == CDG_RD_CAPT); // RULE10
        r_d.cas_allow = (r_d.state == CDG_WR_CAS) || (r_d.state == CDG_RD_CAPT)
            || (r_d.state == CDG_RD_CHECK) || (r_d.state == CDG_RD_DRIVE)
            || (r_d.state == CDG_BYPASS); // RULE8

        // Register writes; a set in the same cycle beats a clear
        if (wr_acc && paddr == CDG_CTRL_OFS)
            r_d.ctrl = pwdata[1:0];
        if (wr_acc && paddr == CDG_IRQ_MASK_OFS)
            r_d.ev_mask = pwdata[CDG_EV_W-1:0];
        if (wr_acc && paddr == CDG_IRQ_STAT_OFS)
            r_d.ev_stat = r_q.ev_stat & ~pwdata[CDG_EV_W-1:0];
        r_d.ev_stat = r_d.ev_stat | ev_set;

        // Read data latched in setup so it is stable through the access phase
        if (rd_acc)
        begin
            case (paddr)
                CDG_CTRL_OFS: r_d.rdata = {30'h0, r_q.ctrl};
                CDG_STAT_OFS: r_d.rdata = {24'h0, r_q.ref_req, r_q.ready_dly,
                    r_q.seq_a, r_q.seq_b, r_q.cas_allow, r_q.state};
                CDG_IRQ_STAT_OFS: r_d.rdata = {27'h0, r_q.ev_stat};
                CDG_IRQ_MASK_OFS: r_d.rdata = {27'h0, r_q.ev_mask};
                default: r_d.rdata = 32'h0;
            endcase
        end
    end

    // Single state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r_q <= '0;
            r_q.state <= CDG_IDLE;
            r_q.ref_req <= 1'b1;
            r_q.ready_dly <= 1'b1;
            r_q.ctrl <= CDG_CTRL_RESET;
            r_q.ev_mask <= CDG_MASK_RESET;
        end
        else
            r_q <= r_d;
    end

    assign prdata = r_q.rdata;
    assign irq = |(r_q.ev_stat & r_q.ev_mask);
    assign cpu_ready = r_q.ready_dly;
    assign refresh_request = r_q.ref_req;
    assign ecc_sequence_a = r_q.seq_a;
    assign ecc_sequence_b = r_q.seq_b;
    assign column_strobe_allow = r_q.cas_allow;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    ready_delayed_a: assert property (cpu_ready == $past(ctrl_ready)) // RULE6
        else $error("processor ready is not the delayed controller ready");
    refresh_follows_a: assert property (memory_cycle_enable_n |=> refresh_request) // RULE3
        else $error("refresh request missed an idle enable");
    refresh_min_high_a: assert property ($rose(refresh_request) |-> // RULE4
        refresh_request[*2])
        else $error("refresh request shorter than two clocks");
    idle_lines_low_a: assert property (r_q.state == CDG_IDLE |-> // RULE7
        !ecc_sequence_a && !ecc_sequence_b)
        else $error("sequence lines not low while generating check bits");
    write_cas_wait_a: assert property ($rose(r_q.state == CDG_WR_GEN) |-> // RULE8
        (!column_strobe_allow)[*2])
        else $error("column strobe allowed before check bits ready");
    read_capture_a: assert property (cycle_start && !cpu_write && r_q.ctrl[0] && // RULE9
        r_q.state == CDG_IDLE && !memory_cycle_enable_n |=> $rose(ecc_sequence_a))
        else $error("read did not raise first sequence line");
    latch_before_drive_a: assert property ($fell(ecc_sequence_b) && // RULE10
        !memory_cycle_enable_n |-> ecc_sequence_a)
        else $error("second line fell without first line high");
    drive_after_check_a: assert property ($fell(ecc_sequence_a) && // RULE13
        r_q.state == CDG_RD_DRIVE |-> $past(ecc_sequence_b, 2) == 1'b0)
        else $error("data driven before the check ran");
    single_flag_a: assert property (r_q.state == CDG_RD_DRIVE && single_error_flag // RULE11
        |=> r_q.ev_stat[CDG_EV_SINGLE])
        else $error("single error not recorded");
    double_flag_a: assert property (r_q.state == CDG_RD_DRIVE && double_error_flag // RULE12
        |=> r_q.ev_stat[CDG_EV_DOUBLE])
        else $error("double error not recorded");
    wait_event_a: assert property (!ctrl_ready && !access_read_strobe_n |=> // RULE5
        r_q.ev_stat[CDG_EV_WAIT])
        else $error("controller wait not recorded");
    // Sequence bounds: a read check must end inside the cycle that started it
    read_in_cycle_a: assert property ($rose(ecc_sequence_a) |-> // RULE14
        ##[1:SEQ_MAX] !ecc_sequence_a)
        else $error("read check outlasted its time budget");
    late_event_a: assert property (memory_cycle_enable_n && // RULE14
        (r_q.state == CDG_WR_GEN || r_q.state == CDG_RD_CAPT || r_q.state == CDG_RD_CHECK)
        |=> r_q.ev_stat[CDG_EV_LATE])
        else $error("cycle cut short without a late event");
    // Refresh window: never dropped while idle, never held low past the limit
    refresh_drop_a: assert property ($fell(refresh_request) |-> // RULE3
        !$past(memory_cycle_enable_n))
        else $error("refresh request dropped while the bus was idle");
    refresh_max_low_a: assert property ($fell(refresh_request) |-> // RULE4
        ##[1:LOW_MAX] refresh_request)
        else $error("refresh request held low too long");
    // Gating and flag capture around the correction unit
    write_gen_gate_a: assert property (r_q.state == CDG_WR_GEN |-> // RULE8
        !column_strobe_allow)
        else $error("column strobe allowed while check bits form");
    capture_lines_a: assert property (r_q.state == CDG_RD_CAPT |-> // RULE9
        ecc_sequence_a && ecc_sequence_b)
        else $error("capture without both sequence lines high");
    set_beats_clear_a: assert property (ev_set[CDG_EV_SINGLE] |=> // RULE11
        r_q.ev_stat[CDG_EV_SINGLE])
        else $error("single error event lost to a clear");

    read_seq_c: cover property (r_q.state == CDG_RD_CHECK ##[1:4] r_q.state == CDG_RD_DRIVE);
    write_seq_c: cover property (r_q.state == CDG_WR_GEN ##[1:4] r_q.state == CDG_WR_CAS);
    wait_seen_c: cover property (!ctrl_ready && !access_read_strobe_n);
    starve_c: cover property (r_d.ev_stat[CDG_EV_STARVE] && !r_q.ev_stat[CDG_EV_STARVE]);
endmodule
`default_nettype wire

/* tb/cdg_far_model.sv */
// Far-side model: controller ready line and correction unit flags
`default_nettype none
module cdg_far_model
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic access_read_strobe_n,
    input wire logic ecc_sequence_a,
    input wire logic ecc_sequence_b,
    input wire logic refresh_start,
    input wire logic [1:0] err_mode,
    output logic ctrl_ready,
    output logic single_error_flag,
    output logic double_error_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ref_cnt_q;
    logic seq_b_q;
    // An access landing on a running internal refresh gets a wait
    assign ctrl_ready = !((ref_cnt_q != 3'h0) && !access_read_strobe_n);
    // Flags held to the end of the cycle so the drive phase still sees them
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ref_cnt_q <= 3'h0;
            seq_b_q <= 1'b0;
            single_error_flag <= 1'b0;
            double_error_flag <= 1'b0;
        end
        else
        begin
            seq_b_q <= ecc_sequence_b;
            if (refresh_start)
                ref_cnt_q <= 3'h6;
            else if (ref_cnt_q != 3'h0)
                ref_cnt_q <= ref_cnt_q - 3'h1;
            if (seq_b_q && !ecc_sequence_b)
            begin
                single_error_flag <= (err_mode == 2'h1);
                double_error_flag <= (err_mode == 2'h2);
            end
            else if (access_read_strobe_n)
            begin
                single_error_flag <= 1'b0;
                double_error_flag <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/cdg_glue_tb_top.sv */
// Self-checking bench for the processor to DRAM glue
`default_nettype none
module cdg_glue_tb_top
    import cdg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MC = 4;
    logic clk = 1'b0;
    logic resetn, psel, penable, pwrite, memory_cycle_enable_n, cpu_write, refresh_start;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, irq, cpu_ready, access_read_strobe_n, address_latch_strobe, er;
    logic refresh_request, ctrl_ready, column_strobe_allow, ecc_sequence_a, ecc_sequence_b;
    logic single_error_flag, double_error_flag;
    logic [1:0] err_mode;
    int n_mismatch = 0;
    int compares = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    cdg_glue #(.MEM_CYCLE_CLKS(MC)) i_cdg_glue (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .memory_cycle_enable_n(memory_cycle_enable_n), .cpu_write(cpu_write),
        .cpu_ready(cpu_ready), .access_read_strobe_n(access_read_strobe_n),
        .address_latch_strobe(address_latch_strobe), .refresh_request(refresh_request),
        .ctrl_ready(ctrl_ready), .column_strobe_allow(column_strobe_allow),
        .ecc_sequence_a(ecc_sequence_a), .ecc_sequence_b(ecc_sequence_b),
        .single_error_flag(single_error_flag), .double_error_flag(double_error_flag));
    cdg_far_model i_cdg_far_model (.clk(clk), .resetn(resetn),
        .access_read_strobe_n(access_read_strobe_n), .ecc_sequence_a(ecc_sequence_a),
        .ecc_sequence_b(ecc_sequence_b), .refresh_start(refresh_start), .err_mode(err_mode),
        .ctrl_ready(ctrl_ready), .single_error_flag(single_error_flag),
        .double_error_flag(double_error_flag));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Settle past the edge before looking
    task step;
        @(posedge clk);
        #1;
    endtask
    // One APB transfer; waits on pready, no assumed latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        chk(pready, 1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Open a memory cycle; strobes must fall together one clock later
    task automatic start_cycle(input logic w, input logic [1:0] e);
        @(posedge clk);
        cpu_write <= w;
        err_mode <= e;
        memory_cycle_enable_n <= 1'b0;
        step;
        chk(access_read_strobe_n, 0);
        chk(address_latch_strobe, 0);
    endtask
    task end_cycle;
        @(posedge clk);
        memory_cycle_enable_n <= 1'b1;
        repeat (3) step;
        chk(access_read_strobe_n, 1);
        chk(address_latch_strobe, 1);
    endtask
    task t_reset;
        chk(access_read_strobe_n, 1);
        chk(address_latch_strobe, 1);
        chk({ecc_sequence_a, ecc_sequence_b}, 0);
        chk(cpu_ready, 1);
        apb(1'b0, CDG_CTRL_OFS, 32'h0);
        chk(rd, 32'(CDG_CTRL_RESET));
        apb(1'b0, CDG_IRQ_MASK_OFS, 32'h0);
        chk(rd, 32'(CDG_MASK_RESET));
        apb(1'b1, 8'h10, 32'hffff_ffff);
        chk(er, 1);
        apb(1'b0, 8'h10, 32'h0);
        chk(er, 1);
        chk(rd, 0);
        $display("t_reset done");
    endtask
    // Read cycles with no error, single and double error
    task t_read;
        apb(1'b1, CDG_IRQ_MASK_OFS, 32'h3);
        for (int i = 0; i < 3; i++)
        begin
            start_cycle(1'b0, 2'(i));
            chk({ecc_sequence_a, ecc_sequence_b, column_strobe_allow}, 3'h7);
            repeat (CDG_CAPTURE_CLKS) step;
            for (int j = 0; j < CDG_DETECT_CLKS; j++)
            begin
                chk({ecc_sequence_a, ecc_sequence_b, cpu_ready}, 3'h5);
                step;
            end
            chk(ecc_sequence_a, 0);
            repeat (3) step;
            end_cycle;
            apb(1'b0, CDG_IRQ_STAT_OFS, 32'h0);
            chk(rd, 32'(i != 0) << (i == 1 ? CDG_EV_SINGLE : CDG_EV_DOUBLE));
            chk(irq, i != 0);
            apb(1'b1, CDG_IRQ_STAT_OFS, 32'h1f);
            step;
            chk(irq, 0);
        end
        $display("t_read done");
    endtask
    // Write: column strobe held off during check-bit generation
    task t_write;
        start_cycle(1'b1, 2'h0);
        for (int i = 0; i < CDG_CHECK_GEN_CLKS; i++)
        begin
            chk({column_strobe_allow, ecc_sequence_a, ecc_sequence_b}, 0);
            step;
        end
        chk(column_strobe_allow, 1);
        end_cycle;
        $display("t_write done");
    endtask
    // Refresh follows enable, forced high after a starving low stretch
    task t_refresh;
        int k;
        k = 0;
        chk(refresh_request, 1);
        start_cycle(1'b0, 2'h0);
        step;
        chk(refresh_request, 0);
        while (refresh_request !== 1'b1 && k < 20)
        begin
            step;
            k++;
        end
        chk(k >= 3 * MC - 3 && k <= 3 * MC, 1);
        step;
        chk(refresh_request, 1);
        end_cycle;
        apb(1'b0, CDG_IRQ_STAT_OFS, 32'h0);
        chk(rd[CDG_EV_STARVE], 1);
        apb(1'b1, CDG_IRQ_STAT_OFS, 32'h1f);
        $display("t_refresh done");
    endtask
    // Access on a running refresh: ready drops, reaches processor a clock later
    task t_wait;
        int k;
        k = 0;
        apb(1'b1, CDG_IRQ_MASK_OFS, 32'h1 << CDG_EV_WAIT);
        @(posedge clk);
        refresh_start <= 1'b1;
        @(posedge clk);
        refresh_start <= 1'b0;
        start_cycle(1'b0, 2'h0);
        chk(ctrl_ready, 0);
        step;
        chk(cpu_ready, 0);
        while (ctrl_ready !== 1'b1 && k < 20)
        begin
            step;
            k++;
        end
        chk(cpu_ready, 0);
        step;
        chk(cpu_ready, 1);
        end_cycle;
        apb(1'b0, CDG_IRQ_STAT_OFS, 32'h0);
        chk(rd[CDG_EV_WAIT], 1);
        chk(irq, 1);
        apb(1'b1, CDG_IRQ_STAT_OFS, 32'h1f);
        step;
        chk(irq, 0);
        $display("t_wait done");
    endtask
    // Bypass with forced refresh, then a read cut short before its check ends
    task t_mode;
        apb(1'b1, CDG_CTRL_OFS, 32'h2);
        start_cycle(1'b0, 2'h0);
        step;
        chk({ecc_sequence_a, ecc_sequence_b, column_strobe_allow}, 3'h1);
        chk(refresh_request, 1);
        end_cycle;
        apb(1'b1, CDG_CTRL_OFS, 32'h1);
        start_cycle(1'b0, 2'h0);
        end_cycle;
        apb(1'b0, CDG_IRQ_STAT_OFS, 32'h0);
        chk(rd[CDG_EV_LATE], 1);
        apb(1'b1, CDG_IRQ_STAT_OFS, 32'h1f);
        $display("t_mode done");
    endtask
    initial
    begin
        resetn = 1'b0;
        {psel, penable, pwrite, cpu_write, refresh_start} = 5'h00;
        memory_cycle_enable_n = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_mode = 2'h0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        step;
        t_reset;
        t_read;
        t_write;
        t_refresh;
        t_wait;
        t_mode;
        end_sim;
    end
    // Watchdog: tests need well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        $display("ERROR %0t ns: watchdog expired", $time);
        end_sim;
    end
endmodule
`default_nettype wire
